/* verilog/csic_cfg.svh */
// csic_cfg.svh: offsets, field positions and reset values of the cascade select,
// configuration and interrupt control register bank.
// assumes a 16-bit register address and 16-bit register data.
`ifndef CSIC_CFG_SVH
`define CSIC_CFG_SVH

// register byte offsets
`define CSIC_OFF_DEVICE_SELECT 16'h100a
`define CSIC_OFF_DEVICE_CONFIG 16'h100e
`define CSIC_OFF_IRQ_CONTROL 16'h1010
`define CSIC_OFF_IRQ_STATUS 16'h1012

// cascade device select fields
`define CSIC_SEL_CODE_MSB 1
`define CSIC_SEL_CODE_LSB 0
`define CSIC_SEL_RESET 2'h0

// configuration fields
`define CSIC_CFG_SUPPLY_BIT 0
`define CSIC_CFG_INDEX_MSB 5
`define CSIC_CFG_INDEX_LSB 4
`define CSIC_CFG_STRAP_BIT 7
`define CSIC_CFG_INDEX_RESET 2'h0

// interrupt control fields
`define CSIC_IRQ_EN_MSB 5
`define CSIC_IRQ_EN_LSB 0
`define CSIC_IRQ_MASK_MSB 13
`define CSIC_IRQ_MASK_LSB 8
`define CSIC_IRQ_EDGE_BIT 14
`define CSIC_IRQ_GATE_BIT 15
`define CSIC_IRQ_CTRL_RESET 16'h0000

// interrupt channel numbers
`define CSIC_CH_FLASH_READY 0
`define CSIC_CH_PROTECT 1
`define CSIC_CH_OVERRUN 2
`define CSIC_CH_ECC 3
`define CSIC_CH_RTC 4
`define CSIC_CH_DMA 5

// misc
`define CSIC_DATA_ZERO 16'h0000
`define CSIC_IRQ_IDLE 1'b1

`endif

/* verilog/csic_pkg.sv */
// csic_pkg: types shared by the cascade select / configuration / interrupt bank.
// assumes csic_cfg.svh for the numeric layout.
`default_nettype none

package csic_pkg;

  // one register cycle from the host
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } csic_bus_req_type;

  // interrupt control register image, msb first
  typedef struct packed {
    logic gate;
    logic edge_mode;
    logic [5:0] mask;
    logic [1:0] rsvd;
    logic [5:0] enable;
  } csic_irq_ctrl_type;

endpackage

`default_nettype wire

/* verilog/csic_irq_channel.sv */
// csic_irq_channel: one sticky interrupt status bit with enable and write-one clear.
// assumes source activity is a level or pulse synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none

module csic_irq_channel (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // control
  input wire logic enable_i,
  input wire logic source_i,
  input wire logic clear_i,
  // state
  output logic status_o,
  output logic new_o
);

  logic status;
  logic next_status;

  // a set in the same cycle as a clear wins; a low enable always wins
  assign next_status = enable_i & (source_i | (status & ~clear_i));
  assign new_o = enable_i & source_i & ~status;
  assign status_o = status;

  // sticky status flop
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status <= 1'b0;
    end else begin
      status <= next_status;
    end
  end

endmodule

`default_nettype wire

/* verilog/csic_bank.sv */
// csic_bank: cascade device select, configuration and interrupt control registers.
// assumes a single-cycle host register port, straps and sources synchronous to clk_i.
//
// Behaviour
// - register reads, and writes other than to the device select register, take effect only when the select code equals the identity straps.
// - the device select register sits at 100a, resets to zero, bits 1-0 writable, bits 7-2 read zero.
// - configuration bits are cleared only by the hardware reset, never by a mode reset or boot detect.
// - configuration bit 0 shows the io supply high flag, 0 below 2.0V and 1 above 2.5V.
// - configuration bits 5-4 hold the highest cascade index that steers boot block mapping.
// - configuration bit 7 reads the live interface configuration strap.
// - channels are 0 flash ready, 1 protection, 2 overrun, 3 ecc error, 4 clock, 5 dma done.
// - an enabled channel latches source activity and raises an interrupt when its mask bit is set.
// - a disabled channel holds its status bit cleared whatever the source does.
// - mask bits 13-8 let matching status bits drive the active low interrupt output.
// - with bit 14 at 0 the output is a level held until the interrupt is cleared.
// - with bit 14 at 1 the output pulses low once per interrupt and returns high.
// - bit 15 set allows the output, and setting it with an interrupt pending fires at once.
// - bit 15 at 0 holds the output negated.
// - an interrupt status register shows the six latched channels in bits 5-0.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "csic_cfg.svh"

module csic_bank #(
  parameter int CHANNELS = 6,
  parameter int CODE_W = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // host register port
  input wire csic_pkg::csic_bus_req_type bus_req_i,
  output logic [15:0] rd_data_o,
  output logic rd_hit_o,
  // straps and supply
  input wire logic [CODE_W-1:0] identity_strap_i,
  input wire logic interface_config_i,
  input wire logic io_supply_high_flag_i,
  // interrupt sources and output
  input wire logic [CHANNELS-1:0] irq_source_i,
  output logic irq_n_o,
  // configuration towards the boot mapping and the rest of the device
  output logic [CODE_W-1:0] highest_cascade_index_o,
  output logic device_selected_o
);

  import csic_pkg::*;

  // register state
  logic [CODE_W-1:0] device_select_code;
  logic [CODE_W-1:0] highest_cascade_index;
  csic_irq_ctrl_type irq_ctrl;

  // channel state
  logic [CHANNELS-1:0] irq_status;
  logic [CHANNELS-1:0] irq_new;
  logic [CHANNELS-1:0] status_clear;

  // decode wires
  wire selected;
  wire hit_select;
  wire hit_config;
  wire hit_ctrl;
  wire hit_status;
  wire wr_any;
  wire wr_select;
  wire wr_config;
  wire wr_ctrl;
  wire wr_status;
  wire rd_local;

  // next values
  logic [15:0] next_rd_data;
  logic next_irq_n;
  csic_irq_ctrl_type next_irq_ctrl;

  // interrupt decision wires
  wire [CHANNELS-1:0] masked_pending;
  wire [CHANNELS-1:0] masked_new;
  wire any_pending;
  wire any_new;
  wire gate_rising;
  wire edge_fire;
  wire level_assert;

  // read images
  wire [15:0] select_image;
  wire [15:0] config_image;
  wire [15:0] ctrl_image;
  wire [15:0] status_image;

  // the cascade answers only when the written code names this device
  assign selected = (device_select_code == identity_strap_i);

  // address decode
  assign hit_select = (bus_req_i.addr == `CSIC_OFF_DEVICE_SELECT);
  assign hit_config = (bus_req_i.addr == `CSIC_OFF_DEVICE_CONFIG);
  assign hit_ctrl = (bus_req_i.addr == `CSIC_OFF_IRQ_CONTROL);
  assign hit_status = (bus_req_i.addr == `CSIC_OFF_IRQ_STATUS);

  // write strobes; the select register is written by every device in the
  // cascade, otherwise the host could never move the selection elsewhere
  assign wr_any = bus_req_i.wr & selected;
  assign wr_select = bus_req_i.wr & hit_select;
  assign wr_config = wr_any & hit_config;
  assign wr_ctrl = wr_any & hit_ctrl;
  assign wr_status = wr_any & hit_status;
  assign rd_local = bus_req_i.rd & selected;

  // reserved bits of every register read as zero
  assign select_image = {{(16 - CODE_W){1'b0}}, device_select_code};

  // configuration image: strap, index, supply flag
  assign config_image = {8'h00, interface_config_i, 1'b0, highest_cascade_index, 3'h0,
                         io_supply_high_flag_i};

  // interrupt control image with its reserved pair forced low
  assign ctrl_image = {irq_ctrl.gate, irq_ctrl.edge_mode, irq_ctrl.mask, 2'h0, irq_ctrl.enable};

  // channel bits follow the same numbering as enable and mask
  assign status_image = {{(16 - CHANNELS){1'b0}}, irq_status};

  // read mux; unmapped addresses and unselected devices return zero
  always_comb begin
    next_rd_data = `CSIC_DATA_ZERO;
    if (rd_local) begin
      if (hit_select) begin
        next_rd_data = select_image;
      end else if (hit_config) begin
        next_rd_data = config_image;
      end else if (hit_ctrl) begin
        next_rd_data = ctrl_image;
      end else if (hit_status) begin
        next_rd_data = status_image;
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o <= `CSIC_DATA_ZERO;
      rd_hit_o <= 1'b0;
    end else begin
      rd_data_o <= next_rd_data;
      rd_hit_o <= rd_local;
    end
  end

  // device select register, hardware reset only
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      device_select_code <= `CSIC_SEL_RESET;
    end else if (wr_select) begin
      device_select_code <= bus_req_i.wdata[`CSIC_SEL_CODE_MSB:`CSIC_SEL_CODE_LSB];
    end
  end

  // highest cascade index; there is deliberately no mode reset input here,
  // so a boot detect or a soft reset of the device cannot disturb it
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      highest_cascade_index <= `CSIC_CFG_INDEX_RESET;
    end else if (wr_config) begin
      highest_cascade_index <= bus_req_i.wdata[`CSIC_CFG_INDEX_MSB:`CSIC_CFG_INDEX_LSB];
    end
  end

  // interrupt control write image; reserved bits are never stored
  always_comb begin
    next_irq_ctrl = irq_ctrl;
    if (wr_ctrl) begin
      next_irq_ctrl.enable = bus_req_i.wdata[`CSIC_IRQ_EN_MSB:`CSIC_IRQ_EN_LSB];
      next_irq_ctrl.mask = bus_req_i.wdata[`CSIC_IRQ_MASK_MSB:`CSIC_IRQ_MASK_LSB];
      next_irq_ctrl.edge_mode = bus_req_i.wdata[`CSIC_IRQ_EDGE_BIT];
      next_irq_ctrl.gate = bus_req_i.wdata[`CSIC_IRQ_GATE_BIT];
      next_irq_ctrl.rsvd = 2'h0;
    end
  end

  // interrupt control register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_ctrl <= `CSIC_IRQ_CTRL_RESET;
    end else begin
      irq_ctrl <= next_irq_ctrl;
    end
  end

  // write-one clear of the status register, an alternative to the
  // enable toggle; a new event in the same cycle still wins
  assign status_clear = wr_status ? bus_req_i.wdata[CHANNELS-1:0] : {CHANNELS{1'b0}};

  // one sticky cell per channel; the stored enable gates latching, so a
  // write of enable to 0 wipes the bit and re-arms on the next write of 1
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      csic_irq_channel u_chan (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .enable_i(irq_ctrl.enable[ch]),
        .source_i(irq_source_i[ch]),
        .clear_i(status_clear[ch]),
        .status_o(irq_status[ch]),
        .new_o(irq_new[ch])
      );
    end
  endgenerate

  // masking of the latched and newly latched channels
  assign masked_pending = irq_status & irq_ctrl.mask;
  assign masked_new = irq_new & irq_ctrl.mask;
  assign any_pending = |masked_pending;
  assign any_new = |masked_new;

  // gate going from 0 to 1 by a host write
  assign gate_rising = wr_ctrl & ~irq_ctrl.gate & bus_req_i.wdata[`CSIC_IRQ_GATE_BIT];

  // edge mode fires once in each cycle in which a masked channel newly latches, or once when the
  // gate opens over an interrupt that was already waiting
  assign edge_fire = (irq_ctrl.gate & any_new) | (gate_rising & any_pending);

  // level mode follows the pending set; cleared channels drop it
  assign level_assert = irq_ctrl.gate & any_pending;

  // output select; gate low holds the pin idle, except that the edge term fires in the cycle of the write that sets it
  always_comb begin
    next_irq_n = `CSIC_IRQ_IDLE;
    if (irq_ctrl.edge_mode) begin
      next_irq_n = ~edge_fire;
    end else begin
      next_irq_n = ~level_assert;
    end
  end

  // the output is registered, so it lags the causing event by one clock;
  // a continuous stream of new events in edge mode gives back-to-back pulses
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_n_o <= `CSIC_IRQ_IDLE;
    end else begin
      irq_n_o <= next_irq_n;
    end
  end

  // configuration and selection outputs towards the rest of the device
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      highest_cascade_index_o <= `CSIC_CFG_INDEX_RESET;
      device_selected_o <= 1'b0;
    end else begin
      highest_cascade_index_o <= highest_cascade_index;
      device_selected_o <= selected;
    end
  end

endmodule

`default_nettype wire

/* test/csic_bank_props.sv */
// csic_bank_props: port-level checks of the cascade select, config and irq bank.
// assumes shadow copies of host writes track the bank's registers edge for edge.
`timescale 1ns/1ps
`default_nettype none
module csic_bank_props #(
  parameter int CHANNELS = 6,
  parameter int CODE_W = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // watched ports
  input wire csic_pkg::csic_bus_req_type bus_req_i,
  input wire logic [15:0] rd_data_o,
  input wire logic rd_hit_o,
  input wire logic [CODE_W-1:0] identity_strap_i,
  input wire logic interface_config_i,
  input wire logic io_supply_high_flag_i,
  input wire logic [CHANNELS-1:0] irq_source_i,
  input wire logic irq_n_o,
  input wire logic [CODE_W-1:0] highest_cascade_index_o,
  input wire logic device_selected_o
);
  import csic_pkg::*;
  logic [CODE_W-1:0] code_q;
  logic [CODE_W-1:0] idx_q;
  csic_irq_ctrl_type ctrl_q;
  logic [1:0] cnt;
  // decode of the shadowed state
  wire sel = code_q == identity_strap_i;
  wire wr_ctrl = bus_req_i.wr && sel && bus_req_i.addr == 16'h1010;
  wire [5:0] em = ctrl_q.enable & ctrl_q.mask;
  wire lvl = ctrl_q.gate && !ctrl_q.edge_mode;
  // shadows; cnt saturates so the irq checks only judge settled control values
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      code_q <= '0;
      idx_q <= '0;
      ctrl_q <= '0;
      cnt <= 2'h0;
    end else begin
      if (bus_req_i.wr && bus_req_i.addr == 16'h100a) code_q <= bus_req_i.wdata[CODE_W-1:0];
      if (bus_req_i.wr && sel && bus_req_i.addr == 16'h100e) idx_q <= bus_req_i.wdata[4 +: CODE_W];
      if (wr_ctrl) ctrl_q <= bus_req_i.wdata;
      cnt <= wr_ctrl ? 2'h0 : (cnt == 2'h3 ? cnt : cnt + 2'h1);
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_rd_idle: assert property (!bus_req_i.rd |=> rd_data_o == 16'h0000 && !rd_hit_o) else $error("read port not idle");
  a_hit_sel: assert property (bus_req_i.rd |=> rd_hit_o == $past(sel)) else $error("read answered off select");
  a_sel_read: assert property (bus_req_i.rd && bus_req_i.addr == 16'h100a |=> !rd_hit_o
    || rd_data_o == 16'($past(code_q))) else $error("select readback wrong");
  a_cfg_read: assert property (bus_req_i.rd && bus_req_i.addr == 16'h100e |=> !rd_hit_o
    || rd_data_o == {8'h00, $past(interface_config_i), 1'b0, $past(idx_q), 3'h0, $past(io_supply_high_flag_i)})
    else $error("config readback wrong");
  a_index_copy: assert property (highest_cascade_index_o == $past(idx_q)) else $error("index output wrong");
  a_select_out: assert property (device_selected_o == $past(sel)) else $error("select output wrong");
  a_gate_off: assert property (!ctrl_q.gate && cnt != 2'h0 |-> irq_n_o) else $error("irq with gate off");
  a_quiet_off: assert property (cnt == 2'h3 && em == 6'h00 |-> irq_n_o) else $error("irq from dead channel");
  a_level_set: assert property (lvl && |(irq_source_i[5:0] & em) ##1 cnt != 2'h0 |=> !irq_n_o)
    else $error("level irq missing");
  a_level_hold: assert property (!irq_n_o && lvl && cnt == 2'h3 && !$past(bus_req_i.wr) |=> !irq_n_o)
    else $error("level irq dropped");
endmodule
`default_nettype wire

/* test/csic_host.sv */
// csic_host: host cpu model issuing single-cycle register strobes.
// assumes the bank never stalls; each strobe is followed by one idle cycle.
`timescale 1ns/1ps
`default_nettype none
module csic_host (
  // clock
  input wire logic clk_i,
  // register request
  output var csic_pkg::csic_bus_req_type bus_req_o
);
  import csic_pkg::*;
  initial bus_req_o = '0;
  // the idle cycle keeps a strobe from being reassigned within one time step
  task automatic op(input logic wr, input logic rd, input logic [15:0] addr, input logic [15:0] data);
    bus_req_o <= '{addr: addr, wdata: data, wr: wr, rd: rd};
    @(posedge clk_i);
    bus_req_o <= '0;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* test/csic_bank_tb.sv */
// csic_bank_tb: self-checking bench for the cascade select, config and irq bank.
// assumes csic_host drives the register port; straps sit at identity 1 but for one deselect check.
`timescale 1ns/1ps
`default_nettype none
module csic_bank_tb;
  import csic_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  wire csic_bus_req_type bus_req;
  wire [15:0] rd_data;
  wire rd_hit, irq_n, dev_sel;
  wire [1:0] index;
  logic ifc = 1'b0, sup = 1'b0, rd_d = 1'b0;
  logic [1:0] strap = 2'h1;
  logic [5:0] src = 6'h00;
  logic [16:0] exp_q[$];
  int failures = 0, samples_checked = 0, seed = 23, lows;
  csic_host u_host (.clk_i(clk_i), .bus_req_o(bus_req));
  csic_bank u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_req_i(bus_req), .rd_data_o(rd_data),
    .rd_hit_o(rd_hit), .identity_strap_i(strap), .interface_config_i(ifc), .io_supply_high_flag_i(sup),
    .irq_source_i(src), .irq_n_o(irq_n), .highest_cascade_index_o(index), .device_selected_o(dev_sel));
  initial forever #20 clk_i = ~clk_i;
  task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    u_host.op(1'b1, 1'b0, a, d);
  endtask
  // the note goes in before the strobe so the watcher always finds it
  task automatic rd(input logic [15:0] a, input logic [16:0] e);
    exp_q.push_back(e);
    u_host.op(1'b0, 1'b1, a, 16'h0000);
  endtask
  task automatic pulse(input int ch);
    src <= 6'h01 << ch;
    @(posedge clk_i);
    src <= 6'h00;
    repeat (3) @(posedge clk_i);
  endtask
  // read answers stand only in the cycle after the strobe, so look exactly there
  always @(posedge clk_i) begin
    if (rd_d) check("read", {rd_hit, rd_data}, exp_q.pop_front());
    rd_d <= bus_req.rd;
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    failures++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    rd(16'h100a, 17'h00000);
    wr(16'h1010, 16'h8101);
    wr(16'h100a, 16'hfffd);
    rd(16'h100a, 17'h10001);
    rd(16'h1010, 17'h10000);
    wr(16'h100e, 16'hffff);
    for (int i = 0; i < 4; i++) begin
      {ifc, sup} <= 2'($random(seed));
      @(posedge clk_i);
      rd(16'h100e, {1'b1, 8'h00, ifc, 1'b0, 2'h3, 3'h0, sup});
    end
    rd(16'h1100, 17'h10000);
    check("index", 17'(index), 17'h00003);
    check("selected", 17'(dev_sel), 17'h00001);
    // moving the straps away from the code must silence this device
    strap <= 2'h2;
    rd(16'h100a, 17'h00000);
    check("deselected", 17'(dev_sel), 17'h00000);
    strap <= 2'h1;
    $display("registers done");
    for (int ch = 0; ch < 6; ch++) begin
      wr(16'h1010, 16'h8000 | (16'h0101 << ch));
      pulse(ch);
      check("irq level", 17'(irq_n), 17'h00000);
      rd(16'h1012, 17'h10000 | (17'h00001 << ch));
      wr(16'h1010, 16'h8000 | (16'h0100 << ch));
      wr(16'h1010, 16'h8000 | (16'h0101 << ch));
      repeat (3) @(posedge clk_i);
      check("irq cleared", 17'(irq_n), 17'h00001);
    end
    wr(16'h1010, 16'h8001);
    pulse(0);
    rd(16'h1012, 17'h10001);
    check("irq unmasked", 17'(irq_n), 17'h00001);
    wr(16'h1010, 16'h0101);
    repeat (3) @(posedge clk_i);
    check("irq gated", 17'(irq_n), 17'h00001);
    wr(16'h1010, 16'h8101);
    repeat (2) @(posedge clk_i);
    check("irq on gate", 17'(irq_n), 17'h00000);
    wr(16'h1010, 16'h8100);
    pulse(0);
    rd(16'h1012, 17'h10000);
    $display("level irq done");
    wr(16'h1010, 16'hc101);
    for (int n = 0; n < 2; n++) begin
      lows = 0;
      src <= 6'h01;
      for (int i = 0; i < 6; i++) begin
        @(posedge clk_i);
        if (i == 0) src <= 6'h00;
        lows += (irq_n === 1'b0);
      end
      check("edge pulses", 17'(lows), n == 0 ? 17'h00001 : 17'h00000);
    end
    $display("edge irq done");
    // a hardware reset in mid-run must wipe the select code and the index
    reset_n_i <= 1'b0;
    @(posedge clk_i);
    check("reset index", 17'(index), 17'h00000);
    check("reset irq", 17'(irq_n), 17'h00001);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    rd(16'h100a, 17'h00000);
    wr(16'h100a, 16'h0001);
    rd(16'h100e, {1'b1, 8'h00, ifc, 1'b0, 2'h0, 3'h0, sup});
    $display("reset done");
    test_done();
  end
endmodule
bind csic_bank csic_bank_props #(.CHANNELS(CHANNELS), .CODE_W(CODE_W)) u_props (.clk_i, .reset_n_i, .bus_req_i,
  .rd_data_o, .rd_hit_o, .identity_strap_i, .interface_config_i, .io_supply_high_flag_i, .irq_source_i,
  .irq_n_o, .highest_cascade_index_o, .device_selected_o);
`default_nettype wire
